// [shared/bias_diag_pkg.sv]
// constants for the bias load-current fault diagnostic register bank
package bias_diag_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] FAULT_LATCH_OFFSET = 8'h37;
    localparam logic [7:0] HIGH_THR_OFFSET    = 8'h38;
    localparam logic [7:0] LOW_THR_OFFSET     = 8'h39;
    localparam logic [7:0] PD_SELECT_OFFSET   = 8'h3A;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] HIGH_THR_RESET     = 8'hBA;
    localparam logic [7:0] LOW_THR_RESET      = 8'h4B;
    localparam logic [7:0] PD_SELECT_RESET    = 8'h10;
    localparam logic [7:0] FAULT_LATCH_RESET  = 8'h00;

    // ------------------------------------------------------------
    // field positions and codes
    // ------------------------------------------------------------
    localparam int         EN_A_BIT           = 7;
    localparam int         EN_B_BIT           = 6;
    localparam int         EN_C_BIT           = 5;
    localparam int         EN_D_BIT           = 4;
    localparam int         RSVD_RW_BIT        = 3;
    localparam logic [7:0] PD_SELECT_WMASK    = 8'hF8;
    localparam int         LATCH_HIGH_BIT     = 7;
    localparam int         LATCH_LOW_BIT      = 6;
    localparam int         LATCH_OV_BIT       = 5;
    localparam logic [7:0] TRIP_CODE_ZERO_MA  = 8'h39;
    localparam logic [7:0] TRIP_CODE_MAX      = 8'hF2;
    localparam logic [1:0] MODE_ONE           = 2'h1;
    localparam logic [1:0] MODE_TWO           = 2'h2;
endpackage : bias_diag_pkg

// [verilog/bias_fault_diag.sv]
// bias load-current fault diagnostic configuration and powerdown control
// ------------------------------------------------------------
// ------------------------------------------------------------
module bias_fault_diag
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic [7:0] bias_current_code,
    input  wire logic       bias_current_valid,
    input  wire logic       over_voltage_pin,
    input  wire logic       over_temp_pin,
    input  wire logic [1:0] fault_shutdown_mode,
    output logic            bias_powerdown,
    output logic            adc_powerdown
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] high_thr_reg;
    logic [7:0] high_thr_next;
    logic [7:0] low_thr_reg;
    logic [7:0] low_thr_next;
    logic [7:0] pd_select_reg;
    logic [7:0] pd_select_next;
    logic [7:0] fault_latch_reg;
    logic [7:0] fault_latch_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       shutdown_reg;
    logic       shutdown_next;
    logic [2:0] ov_sync_reg;
    logic [2:0] ot_sync_reg;
    logic       ov_level_reg;
    logic       ov_level_next;
    logic       ot_level_reg;
    logic       ot_level_next;

    logic       high_fault;
    logic       low_fault;
    logic       trip;
    logic       latch_read;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // register hit on an access
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
        hit = (addr == offset);
    endfunction : hit

    // ------------------------------------------------------------
    // fault detection
    // ------------------------------------------------------------
    // measured code shares the trip code scale, so codes compare directly
    always_comb
    begin
        high_fault = bias_current_valid && (bias_current_code > high_thr_reg);
        low_fault  = bias_current_valid && (bias_current_code < low_thr_reg);
    end

    // shutdown selection per mode and enable
    always_comb
    begin
        trip = 1'b0;
        case (fault_shutdown_mode)
            bias_diag_pkg::MODE_ONE:
            begin
                trip = (pd_select_reg[bias_diag_pkg::EN_A_BIT] && (high_fault || low_fault))
                    || (pd_select_reg[bias_diag_pkg::EN_B_BIT] && ov_level_reg)
                    || (pd_select_reg[bias_diag_pkg::EN_C_BIT] && ot_level_reg)
                    || (pd_select_reg[bias_diag_pkg::EN_D_BIT] && high_fault);
            end
            bias_diag_pkg::MODE_TWO:
            begin
                trip = (pd_select_reg[bias_diag_pkg::EN_A_BIT] && (high_fault || low_fault))
                    || (pd_select_reg[bias_diag_pkg::EN_B_BIT] && low_fault)
                    || (pd_select_reg[bias_diag_pkg::EN_C_BIT] && ov_level_reg)
                    || (pd_select_reg[bias_diag_pkg::EN_D_BIT] && ot_level_reg);
            end
            default:
            begin
                trip = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // level follows once stages two and three agree
    always_comb
    begin
        ov_level_next = (ov_sync_reg[1] == ov_sync_reg[2]) ? ov_sync_reg[2] : ov_level_reg;
        ot_level_next = (ot_sync_reg[1] == ot_sync_reg[2]) ? ot_sync_reg[2] : ot_level_reg;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ov_sync_reg  <= 3'h0;
            ot_sync_reg  <= 3'h0;
            ov_level_reg <= 1'b0;
            ot_level_reg <= 1'b0;
        end
        else
        begin
            ov_sync_reg  <= {ov_sync_reg[1:0], over_voltage_pin};
            ot_sync_reg  <= {ot_sync_reg[1:0], over_temp_pin};
            ov_level_reg <= ov_level_next;
            ot_level_reg <= ot_level_next;
        end
    end

    // ------------------------------------------------------------
    // register bank
    // ------------------------------------------------------------
    assign latch_read = reg_read && hit(reg_addr, bias_diag_pkg::FAULT_LATCH_OFFSET);

    // writes, read data and latch update
    always_comb
    begin
        high_thr_next  = high_thr_reg;
        low_thr_next   = low_thr_reg;
        pd_select_next = pd_select_reg;
        if (reg_write && hit(reg_addr, bias_diag_pkg::HIGH_THR_OFFSET))
        begin
            high_thr_next = reg_wdata; // reserved codes stored as written
        end
        if (reg_write && hit(reg_addr, bias_diag_pkg::LOW_THR_OFFSET))
        begin
            low_thr_next = reg_wdata;
        end
        if (reg_write && hit(reg_addr, bias_diag_pkg::PD_SELECT_OFFSET))
        begin
            // bits 2..0 are read-only zero
            pd_select_next = reg_wdata & bias_diag_pkg::PD_SELECT_WMASK;
        end
        // read clears, a new fault in the same cycle wins
        fault_latch_next = latch_read ? 8'h00 : fault_latch_reg;
        fault_latch_next[bias_diag_pkg::LATCH_HIGH_BIT] =
            fault_latch_next[bias_diag_pkg::LATCH_HIGH_BIT] | high_fault;
        fault_latch_next[bias_diag_pkg::LATCH_LOW_BIT] =
            fault_latch_next[bias_diag_pkg::LATCH_LOW_BIT] | low_fault;
        fault_latch_next[bias_diag_pkg::LATCH_OV_BIT] =
            fault_latch_next[bias_diag_pkg::LATCH_OV_BIT] | ov_level_reg;
        rdata_next = rdata_reg;
        if (reg_read)
        begin
            case (reg_addr)
                bias_diag_pkg::FAULT_LATCH_OFFSET: rdata_next = fault_latch_reg;
                bias_diag_pkg::HIGH_THR_OFFSET:    rdata_next = high_thr_reg;
                bias_diag_pkg::LOW_THR_OFFSET:     rdata_next = low_thr_reg;
                bias_diag_pkg::PD_SELECT_OFFSET:   rdata_next = pd_select_reg;
                default:                           rdata_next = 8'h00;
            endcase
        end
        // powerdown holds until reset once tripped
        shutdown_next = shutdown_reg | trip;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            high_thr_reg    <= bias_diag_pkg::HIGH_THR_RESET;
            low_thr_reg     <= bias_diag_pkg::LOW_THR_RESET;
            pd_select_reg   <= bias_diag_pkg::PD_SELECT_RESET;
            fault_latch_reg <= bias_diag_pkg::FAULT_LATCH_RESET;
            rdata_reg       <= 8'h00;
            shutdown_reg    <= 1'b0;
        end
        else
        begin
            high_thr_reg    <= high_thr_next;
            low_thr_reg     <= low_thr_next;
            pd_select_reg   <= pd_select_next;
            fault_latch_reg <= fault_latch_next;
            rdata_reg       <= rdata_next;
            shutdown_reg    <= shutdown_next;
        end
    end

    // outputs
    assign reg_rdata      = rdata_reg;
    assign bias_powerdown = shutdown_reg;
    assign adc_powerdown  = shutdown_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_high_thr_reset: assert property (
        $past(rst) |-> high_thr_reg == bias_diag_pkg::HIGH_THR_RESET)
        else $error("high trip code not at reset value");
    a_low_thr_reset: assert property (
        $past(rst) |-> low_thr_reg == bias_diag_pkg::LOW_THR_RESET)
        else $error("low trip code not at reset value");
    a_enable_reset_value: assert property (
        $past(rst) |-> pd_select_reg == bias_diag_pkg::PD_SELECT_RESET)
        else $error("shutdown enables not at reset value");
    a_clear_enable_idle: assert property (
        pd_select_reg[7:4] == 4'h0 && !shutdown_reg |=> !bias_powerdown && !adc_powerdown)
        else $error("powerdown without an enabled fault");
    a_trip_powers_down: assert property (trip |=> bias_powerdown && adc_powerdown)
        else $error("enabled fault did not power down");
    a_enable_a_current: assert property (
        fault_shutdown_mode == 2'h2 && pd_select_reg[7] && low_fault |=> adc_powerdown)
        else $error("enable a ignored a current fault");
    a_enable_d_temp: assert property (
        fault_shutdown_mode == 2'h2 && pd_select_reg[4] && ot_level_reg |=> bias_powerdown)
        else $error("enable d ignored over-temperature");
    a_enable_b_ov: assert property (
        fault_shutdown_mode == 2'h1 && pd_select_reg[6] && ov_level_reg |=> bias_powerdown)
        else $error("enable b ignored over-voltage");
    a_enable_c_ov: assert property (
        fault_shutdown_mode == 2'h2 && pd_select_reg[5] && ov_level_reg |=> bias_powerdown)
        else $error("enable c ignored over-voltage");
    a_latch_high_set: assert property (high_fault |=> fault_latch_reg[7])
        else $error("high fault not latched");
    a_latch_read_clear: assert property (
        latch_read && !low_fault |=> !fault_latch_reg[6])
        else $error("low fault latch not cleared by read");
    a_high_compare: assert property (
        bias_current_valid && bias_current_code > high_thr_reg |-> high_fault)
        else $error("high compare missed");
    a_rsvd_bits_zero: assert property (pd_select_reg[2:0] == 3'h0)
        else $error("read-only reserved bits not zero");

    // ------------------------------------------------------------
    // register access, latch and shutdown checks
    // ------------------------------------------------------------
    // writes land on the next edge, reads return the value held before
    a_low_thr_write: assert property (
        reg_write && reg_addr == bias_diag_pkg::LOW_THR_OFFSET
        |=> low_thr_reg == $past(reg_wdata))
        else $error("low trip code write lost");
    a_high_thr_read: assert property (
        reg_read && reg_addr == bias_diag_pkg::HIGH_THR_OFFSET
        |=> reg_rdata == $past(high_thr_reg))
        else $error("high trip code read back wrong");
    a_select_write: assert property (
        reg_write && reg_addr == bias_diag_pkg::PD_SELECT_OFFSET
        |=> pd_select_reg[7:3] == $past(reg_wdata[7:3]))
        else $error("shutdown enable write lost");

    // latch bits follow their faults, reserved bits stay clear
    a_latch_low_set: assert property (
        bias_current_valid && bias_current_code < low_thr_reg
        |=> fault_latch_reg[bias_diag_pkg::LATCH_LOW_BIT])
        else $error("low fault not latched");
    a_latch_ov_set: assert property (
        ov_level_reg |=> fault_latch_reg[bias_diag_pkg::LATCH_OV_BIT])
        else $error("over-voltage fault not latched");
    a_latch_rsvd_zero: assert property (
        fault_latch_reg[4:0] == 5'h00)
        else $error("latch reserved bits not zero");

    // both powerdowns move together and hold until reset
    a_powerdown_sticky: assert property (
        bias_powerdown |=> bias_powerdown && adc_powerdown)
        else $error("powerdown released without reset");
    a_powerdown_pair: assert property (
        bias_powerdown == adc_powerdown)
        else $error("bias and converter powerdown differ");
    a_other_mode_idle: assert property (
        fault_shutdown_mode != bias_diag_pkg::MODE_ONE
        && fault_shutdown_mode != bias_diag_pkg::MODE_TWO |-> !trip)
        else $error("shutdown selected in an idle mode");
    a_enable_a_high: assert property (
        fault_shutdown_mode == bias_diag_pkg::MODE_ONE
        && pd_select_reg[bias_diag_pkg::EN_A_BIT] && high_fault |=> bias_powerdown)
        else $error("enable a ignored a high current fault");
    a_enable_b_low: assert property (
        fault_shutdown_mode == bias_diag_pkg::MODE_TWO
        && pd_select_reg[bias_diag_pkg::EN_B_BIT] && low_fault |=> bias_powerdown)
        else $error("enable b ignored a low current fault");
    a_enable_c_temp: assert property (
        fault_shutdown_mode == bias_diag_pkg::MODE_ONE
        && pd_select_reg[bias_diag_pkg::EN_C_BIT] && ot_level_reg |=> bias_powerdown)
        else $error("enable c ignored over-temperature");
    a_enable_d_high: assert property (
        fault_shutdown_mode == bias_diag_pkg::MODE_ONE
        && pd_select_reg[bias_diag_pkg::EN_D_BIT] && high_fault |=> adc_powerdown)
        else $error("enable d ignored a high current fault");

    // main scenarios
    c_mode_one_trip: cover property (fault_shutdown_mode == 2'h1 ##1 trip);
    c_mode_two_trip: cover property (fault_shutdown_mode == 2'h2 ##1 trip);
    c_latch_read: cover property (fault_latch_reg[7] ##1 latch_read);
    c_set_on_clear: cover property (latch_read && high_fault);
    c_temp_shutdown: cover property (ot_level_reg ##1 bias_powerdown);
endmodule : bias_fault_diag

// [test/tb_top.sv]
// self-checking bench for the bias fault diagnostic register bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk                 = 1'b0;
    logic       rst                 = 1'b1;
    logic [7:0] reg_addr            = 8'h00;
    logic [7:0] reg_wdata           = 8'h00;
    logic       reg_write           = 1'b0;
    logic       reg_read            = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] bias_current_code   = 8'h80;
    logic       bias_current_valid  = 1'b1;
    logic       over_voltage_pin    = 1'b0;
    logic       over_temp_pin       = 1'b0;
    logic [1:0] fault_shutdown_mode = 2'h0;
    logic       bias_powerdown;
    logic       adc_powerdown;
    int         errors              = 0;
    int         check_count         = 0;
    int         cycles              = 0;

    // ------------------------------------------------------------
    // clock, timeout and design
    // ------------------------------------------------------------
    always #25 clk = ~clk;

    // cut a hang short after far more cycles than the tests need
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            report_and_stop();
        end
    end

    bias_fault_diag u_bias_fault_diag (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .bias_current_code(bias_current_code),
        .bias_current_valid(bias_current_valid), .over_voltage_pin(over_voltage_pin),
        .over_temp_pin(over_temp_pin), .fault_shutdown_mode(fault_shutdown_mode),
        .bias_powerdown(bias_powerdown), .adc_powerdown(adc_powerdown));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic do_reset(input int n);
        @(posedge clk);
        rst <= 1'b1;
        repeat (n) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset

    // one-cycle write strobe
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    // one-cycle read strobe, data registered at the taking edge
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= addr;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    // drive a measured current for n cycles, then return to mid range
    task automatic hold(input logic [7:0] code, input logic valid, input int n);
        @(posedge clk);
        bias_current_code  <= code;
        bias_current_valid <= valid;
        repeat (n) @(posedge clk);
        bias_current_code  <= 8'h80;
        bias_current_valid <= 1'b1;
    endtask : hold

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        rd(bias_diag_pkg::HIGH_THR_OFFSET, 8'hBA);
        rd(bias_diag_pkg::LOW_THR_OFFSET, 8'h4B);
        rd(bias_diag_pkg::PD_SELECT_OFFSET, 8'h10);
        rd(bias_diag_pkg::FAULT_LATCH_OFFSET, 8'h00);
        rd(8'h3B, 8'h00);
        $display("test reset values done");
    endtask : test_reset

    task automatic test_write();
        wr(bias_diag_pkg::HIGH_THR_OFFSET, 8'hF2);
        wr(bias_diag_pkg::LOW_THR_OFFSET, 8'h39);
        wr(bias_diag_pkg::PD_SELECT_OFFSET, 8'hF0);
        wr(bias_diag_pkg::FAULT_LATCH_OFFSET, 8'hE0);
        rd(bias_diag_pkg::HIGH_THR_OFFSET, 8'hF2);
        rd(bias_diag_pkg::LOW_THR_OFFSET, 8'h39);
        rd(bias_diag_pkg::PD_SELECT_OFFSET, 8'hF0);
        rd(bias_diag_pkg::FAULT_LATCH_OFFSET, 8'h00);
        $display("test register write done");
    endtask : test_write

    task automatic test_latch();
        do_reset(2);
        hold(8'hBA, 1'b1, 3);
        hold(8'h4B, 1'b1, 3);
        rd(bias_diag_pkg::FAULT_LATCH_OFFSET, 8'h00);
        hold(8'hF0, 1'b1, 3);
        rd(bias_diag_pkg::FAULT_LATCH_OFFSET, 8'h80);
        rd(bias_diag_pkg::FAULT_LATCH_OFFSET, 8'h00);
        hold(8'h40, 1'b1, 3);
        rd(bias_diag_pkg::FAULT_LATCH_OFFSET, 8'h40);
        hold(8'h00, 1'b0, 3);
        rd(bias_diag_pkg::FAULT_LATCH_OFFSET, 8'h00);
        @(posedge clk);
        over_voltage_pin <= 1'b1;
        repeat (6) @(posedge clk);
        over_voltage_pin <= 1'b0;
        repeat (8) @(posedge clk);
        rd(bias_diag_pkg::FAULT_LATCH_OFFSET, 8'h20);
        rd(bias_diag_pkg::FAULT_LATCH_OFFSET, 8'h00);
        chk({7'h00, bias_powerdown}, 8'h00);
        $display("test fault latch done");
    endtask : test_latch

    // ft: 0 high current, 1 low current, 2 over-voltage, 3 over-temperature
    task automatic pd_case(input logic [1:0] mode, input logic [7:0] sel, input int ft,
                           input logic exp);
        do_reset(2);
        wr(bias_diag_pkg::PD_SELECT_OFFSET, sel);
        @(posedge clk);
        fault_shutdown_mode <= mode;
        bias_current_code   <= (ft == 0) ? 8'hF0 : ((ft == 1) ? 8'h40 : 8'h80);
        over_voltage_pin    <= (ft == 2);
        over_temp_pin       <= (ft == 3);
        repeat (8) @(posedge clk);
        fault_shutdown_mode <= 2'h0;
        bias_current_code   <= 8'h80;
        over_voltage_pin    <= 1'b0;
        over_temp_pin       <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk({7'h00, bias_powerdown}, {7'h00, exp});
        chk({7'h00, adc_powerdown}, {7'h00, exp});
    endtask : pd_case

    task automatic test_shutdown();
        pd_case(2'h1, 8'h80, 0, 1'b1);
        pd_case(2'h2, 8'h80, 1, 1'b1);
        pd_case(2'h1, 8'h40, 2, 1'b1);
        pd_case(2'h2, 8'h40, 1, 1'b1);
        pd_case(2'h1, 8'h20, 3, 1'b1);
        pd_case(2'h2, 8'h20, 2, 1'b1);
        pd_case(2'h1, 8'h10, 0, 1'b1);
        pd_case(2'h2, 8'h10, 3, 1'b1);
        pd_case(2'h2, 8'h40, 3, 1'b0);
        pd_case(2'h1, 8'h10, 1, 1'b0);
        pd_case(2'h2, 8'h00, 0, 1'b0);
        pd_case(2'h0, 8'hF0, 3, 1'b0);
        pd_case(2'h3, 8'hF0, 0, 1'b0);
        $display("test shutdown done");
    endtask : test_shutdown

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_write();
        test_latch();
        test_shutdown();
        report_and_stop();
    end
endmodule : tb_top
